// *** core/dis_core.sv ***
// DDR2 setup-register decoder, phase-lock timer and burst column sequencer.
// Assumes the controller keeps the documented init order and spacing;
// the pins arrive synchronous to clk_in, which stands for the memory clock.
module dis_core
  import dis_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire dis_cmd_s cmd_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  output logic ready_out,
  output logic precharge_all_out,
  output logic burst_active_out,
  output logic burst_write_out,
  output logic [COL_W-1:0] burst_col_out
);
  // Command decode; nothing is taken while the clock gate is low
  logic cmd_load;
  logic cmd_column;
  logic cmd_precharge;
  assign cmd_load = cmd_in.cke & ~cmd_in.cs_n & ~cmd_in.ras_n
                    & ~cmd_in.cas_n & ~cmd_in.we_n;
  assign cmd_column = cmd_in.cke & ~cmd_in.cs_n & cmd_in.ras_n & ~cmd_in.cas_n;
  assign cmd_precharge = cmd_in.cke & ~cmd_in.cs_n & ~cmd_in.ras_n
                         & cmd_in.cas_n & ~cmd_in.we_n;

  // Setup registers, lock timer and error flag
  logic [13:0] main_setup_register;
  logic [13:0] extended_setup_register;
  logic [13:0] extended_setup_register_two;
  logic [13:0] extended_setup_register_three;
  logic [7:0] lock_count;
  logic ready;
  logic setup_error;
  logic precharge_all;
  logic [13:0] next_main;
  logic [13:0] next_ext;
  logic [13:0] next_ext2;
  logic [13:0] next_ext3;
  logic [7:0] next_lock_count;
  logic next_ready;
  logic next_setup_error;
  logic next_precharge_all;
  logic clear_error;
  dis_state_e state;

  assign clear_error = wb_cyc_in & wb_stb_in & wb_we_in & ~wb_ack_out & wb_sel_in[0]
                       & (wb_adr_in == OFF_CONTROL) & wb_dat_in[CTL_CLEAR_ERROR];

  // Loads only touch setup state, never stored data
  always_comb begin
    next_main = main_setup_register;
    next_ext = extended_setup_register;
    next_ext2 = extended_setup_register_two;
    next_ext3 = extended_setup_register_three;
    next_lock_count = lock_count;
    next_ready = ready;
    next_setup_error = setup_error;
    next_precharge_all = cmd_precharge & cmd_in.addr[ADDR_BIT10];
    // Self-clear one cycle after the reset load was registered
    if (main_setup_register[PHASE_LOCK_RESET_BIT]) begin
      next_main[PHASE_LOCK_RESET_BIT] = 1'b0;
    end
    if (lock_count != 8'h00) begin
      next_lock_count = lock_count - 8'h01;
      next_ready = (lock_count == 8'h01);
    end
    if (clear_error) begin
      next_setup_error = 1'b0;
    end
    if (cmd_load) begin
      // A load during a burst is flagged; the set wins over a clear
      if (state == DIS_BURST) begin
        next_setup_error = 1'b1;
      end
      case (cmd_in.bank)
        BANK_MAIN: begin
          next_main = cmd_in.addr;
          if (cmd_in.addr[PHASE_LOCK_RESET_BIT]) begin
            next_lock_count = LOCK_CYCLES;
            next_ready = 1'b0;
          end
        end
        BANK_EXT: next_ext = cmd_in.addr;
        BANK_EXT2: next_ext2 = cmd_in.addr;
        BANK_EXT3: next_ext3 = cmd_in.addr;
        default: next_setup_error = 1'b1; // Bank bit2 is reserved
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      main_setup_register <= SETUP_RESET;
      extended_setup_register <= SETUP_RESET;
      extended_setup_register_two <= SETUP_RESET;
      extended_setup_register_three <= SETUP_RESET;
      lock_count <= 8'h00;
      ready <= 1'b0;
      setup_error <= 1'b0;
      precharge_all <= 1'b0;
    end else begin
      main_setup_register <= next_main;
      extended_setup_register <= next_ext;
      extended_setup_register_two <= next_ext2;
      extended_setup_register_three <= next_ext3;
      lock_count <= next_lock_count;
      ready <= next_ready;
      setup_error <= next_setup_error;
      precharge_all <= next_precharge_all;
    end
  end

  // Burst sequencer: one column per cycle, wrapping within the block
  logic burst_eight;
  logic interleaved;
  logic [2:0] beat;
  logic [2:0] start_col;
  logic [COL_W-1:0] base_col;
  logic burst_write;
  logic [COL_W-1:0] col;
  dis_state_e next_state;
  logic [2:0] next_beat;
  logic [2:0] next_start_col;
  logic [COL_W-1:0] next_base_col;
  logic next_burst_write;
  logic next_burst_eight;
  logic next_interleaved;
  logic [COL_W-1:0] next_col;
  logic [2:0] offset;
  logic [2:0] last_beat;

  // Length and order are latched per command, so a later load cannot skew it
  always_comb begin
    next_state = state;
    next_beat = beat;
    next_start_col = start_col;
    next_base_col = base_col;
    next_burst_write = burst_write;
    next_burst_eight = burst_eight;
    next_interleaved = interleaved;
    next_col = col;
    offset = 3'h0;
    last_beat = burst_eight ? 3'h7 : 3'h3;
    if (state == DIS_BURST) begin
      if (beat == last_beat) begin
        next_state = DIS_IDLE;
      end else begin
        next_beat = beat + 3'h1;
        offset = interleaved ? (start_col ^ next_beat)
                             : (start_col + next_beat);
        if (burst_eight) begin
          next_col = {base_col[COL_W-1:3], offset};
        end else begin
          next_col = {base_col[COL_W-1:2], offset[1:0]};
        end
      end
    end
    if (cmd_column && (next_state == DIS_IDLE)) begin
      next_state = DIS_BURST;
      next_beat = 3'h0;
      next_start_col = cmd_in.addr[2:0];
      next_base_col = cmd_in.addr[COL_W-1:0];
      next_burst_write = ~cmd_in.we_n;
      next_burst_eight = (main_setup_register[2:0] == BURST_LENGTH_EIGHT);
      next_interleaved = main_setup_register[BURST_ORDER_BIT];
      next_col = cmd_in.addr[COL_W-1:0];
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= DIS_IDLE;
      beat <= 3'h0;
      start_col <= 3'h0;
      base_col <= '0;
      burst_write <= 1'b0;
      burst_eight <= 1'b0;
      interleaved <= 1'b0;
      col <= '0;
    end else begin
      state <= next_state;
      beat <= next_beat;
      start_col <= next_start_col;
      base_col <= next_base_col;
      burst_write <= next_burst_write;
      burst_eight <= next_burst_eight;
      interleaved <= next_interleaved;
      col <= next_col;
    end
  end

  // Wishbone slave: ack one cycle after the strobe, unmapped reads give zero
  logic [31:0] next_dat;
  logic next_ack;
  always_comb begin
    next_ack = wb_cyc_in & wb_stb_in & ~wb_ack_out;
    next_dat = 32'h0000_0000;
    case (wb_adr_in)
      OFF_MAIN: next_dat = {18'h00000, main_setup_register};
      OFF_EXT: next_dat = {18'h00000, extended_setup_register};
      OFF_EXT2: next_dat = {18'h00000, extended_setup_register_two};
      OFF_EXT3: next_dat = {18'h00000, extended_setup_register_three};
      OFF_STATUS: begin
        next_dat[ST_READY] = ready;
        next_dat[ST_LOCKING] = (lock_count != 8'h00);
        next_dat[ST_ERROR] = setup_error;
        next_dat[ST_BURST] = (state == DIS_BURST);
        next_dat[ST_COUNT_LSB +: 8] = lock_count;
      end
      default: next_dat = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else begin
      wb_ack_out <= next_ack;
      wb_dat_out <= next_dat;
    end
  end

  // Registered outputs
  assign ready_out = ready;
  assign precharge_all_out = precharge_all;
  assign burst_active_out = (state == DIS_BURST);
  assign burst_write_out = burst_write;
  assign burst_col_out = col;
endmodule

// *** core/dis_pkg.sv ***
// Constants and carriers for the DDR2 setup-register and burst block.
// Assumes commands are sampled on every rising edge of clk_in.
package dis_pkg;
  // Command pins as sampled on one clock edge
  typedef struct packed {
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [2:0] bank;
    logic [13:0] addr;
  } dis_cmd_s;

  // Bank-select codes choosing a setup register
  localparam logic [2:0] BANK_MAIN = 3'h0;
  localparam logic [2:0] BANK_EXT = 3'h1;
  localparam logic [2:0] BANK_EXT2 = 3'h2;
  localparam logic [2:0] BANK_EXT3 = 3'h3;

  // Field positions
  localparam int ADDR_BIT10 = 10;
  localparam int PHASE_LOCK_RESET_BIT = 8;
  localparam int BURST_ORDER_BIT = 3;
  localparam logic [2:0] BURST_LENGTH_EIGHT = 3'h3;
  localparam int COL_W = 10;

  // Lock wait in clock cycles after a phase-lock reset load
  localparam logic [7:0] LOCK_CYCLES = 8'hC8;

  // Reset values
  localparam logic [13:0] SETUP_RESET = 14'h0000;

  // Wishbone byte offsets
  localparam logic [7:0] OFF_MAIN = 8'h00;
  localparam logic [7:0] OFF_EXT = 8'h04;
  localparam logic [7:0] OFF_EXT2 = 8'h08;
  localparam logic [7:0] OFF_EXT3 = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_CONTROL = 8'h14;

  // Status and control bit positions
  localparam int ST_READY = 0;
  localparam int ST_LOCKING = 1;
  localparam int ST_ERROR = 2;
  localparam int ST_BURST = 3;
  localparam int ST_COUNT_LSB = 8;
  localparam int CTL_CLEAR_ERROR = 0;

  typedef enum logic [0:0] {DIS_IDLE, DIS_BURST} dis_state_e;
endpackage

// *** bench/dis_ctrl_model.sv ***
// Controller model driving the command pins of the setup block.
// Assumes the bench calls its tasks from one process, one at a time.
module dis_ctrl_model
  import dis_pkg::*;
(
  input wire logic clk_in,
  output dis_cmd_s cmd_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Power-up: clock gate low, deselected
  initial cmd_out = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 3'h7, 14'h3FFF};
  // One command on one edge; idle pins then show the inverse
  task automatic send(input logic [2:0] op, input logic [2:0] ba, input logic [13:0] a);
    @(posedge clk_in);
    cmd_out <= '{1'b1, 1'b0, op[2], op[1], op[0], ba, a};
    @(posedge clk_in);
    cmd_out <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, ~ba, ~a};
  endtask
  // Power-up order; final main load value picks length eight, sequential
  task automatic init_seq();
    repeat (25000) @(posedge clk_in);
    cmd_out.cke <= 1'b1;
    repeat (50) @(posedge clk_in);
    send(3'h2, 3'h0, 14'h0400);
    send(3'h0, BANK_EXT2, 14'h0080);
    send(3'h0, BANK_EXT3, 14'h0000);
    send(3'h0, BANK_EXT, 14'h0000);
    send(3'h0, BANK_MAIN, 14'h0100);
    send(3'h2, 3'h0, 14'h0400);
    send(3'h1, 3'h0, 14'h0000);
    send(3'h1, 3'h0, 14'h0000);
    send(3'h0, BANK_MAIN, 14'h0003);
    send(3'h0, BANK_EXT, 14'h0380);
    send(3'h0, BANK_EXT, 14'h0000);
  endtask
endmodule

// *** bench/dis_core_checker.sv ***
// Port assertions for the setup-register block.
// Assumes it is bound into dis_core; pins sampled on rising clk_in.
module dis_core_checker
  import dis_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire dis_cmd_s cmd_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_ack_out,
  input wire logic ready_out,
  input wire logic precharge_all_out,
  input wire logic burst_active_out,
  input wire logic [COL_W-1:0] burst_col_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ld, lock_ld, pre_all, start;
  dis_cmd_s c;
  // Command decode from the pins
  assign c = cmd_in;
  assign ld = c.cke & ~c.cs_n & ~c.ras_n & ~c.cas_n & ~c.we_n;
  assign lock_ld = ld & (c.bank == BANK_MAIN) & c.addr[8];
  assign pre_all = c.cke & ~c.cs_n & ~c.ras_n & c.cas_n & ~c.we_n & c.addr[10];
  assign start = c.cke & ~c.cs_n & c.ras_n & ~c.cas_n & ~burst_active_out;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // Lock wait: ready held low for the first 8 cycles after the reset load
  sequence s_lock_wait;
    !ready_out [*8];
  endsequence
  sequence s_min_burst;
    burst_active_out [*4];
  endsequence
  chk_prech_pulse: assert property (precharge_all_out == $past(pre_all))
    else $error("precharge pulse mismatch");
  chk_lock_hold: assert property (lock_ld |=> s_lock_wait)
    else $error("ready high during lock wait");
  chk_ready_late: assert property ($rose(ready_out) |-> $past(lock_ld, 201))
    else $error("ready rose at wrong time");
  chk_ready_keep: assert property (ready_out && !lock_ld |=> ready_out)
    else $error("ready dropped without load");
  chk_burst_four: assert property (start |=> s_min_burst)
    else $error("burst shorter than four");
  chk_first_col: assert property (start |=> burst_col_out == $past(c.addr[COL_W-1:0]))
    else $error("burst start column wrong");
  chk_ack_delay: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("ack late");
  chk_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
endmodule
bind dis_core dis_core_checker u_chk (.clk_in(clk_in), .rst_in(rst_in), .cmd_in(cmd_in),
  .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_ack_out(wb_ack_out),
  .ready_out(ready_out), .precharge_all_out(precharge_all_out),
  .burst_active_out(burst_active_out), .burst_col_out(burst_col_out));

// *** bench/dis_core_tb.sv ***
// Self-checking bench for the setup-register and burst block.
// Assumes the core, its checker bind and the controller model.
module dis_core_tb
  import dis_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0, rst_in = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic ack, rdy, pre, act, bwr;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic [9:0] col, e;
  dis_cmd_s cmd;
  int bad_count = 0, total_checks = 0, cycles = 0, lim, i, m;
  always #4 clk_in = ~clk_in;
  dis_ctrl_model ctl (.clk_in(clk_in), .cmd_out(cmd));
  dis_core uut (.clk_in(clk_in), .rst_in(rst_in), .cmd_in(cmd), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(wdat),
    .wb_dat_out(rdat), .wb_ack_out(ack), .ready_out(rdy), .precharge_all_out(pre),
    .burst_active_out(act), .burst_write_out(bwr), .burst_col_out(col));
  // Closing report from main sequence or timeout
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Word compare; unknowns never match
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Classic cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk_in iff ack === 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // Hang guard; init alone takes about 25100 cycles
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      bad_count++;
      conclude();
    end
  end
  // Reset, map, init order, errors, then all four burst modes
  initial begin
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    wb(1'b0, OFF_STATUS, 32'h0);
    chk(q, 32'h0);
    wb(1'b1, OFF_MAIN, 32'h3FFF);
    wb(1'b0, OFF_MAIN, 32'h0);
    chk(q, 32'h0);
    wb(1'b0, 8'h20, 32'h0);
    chk(q, 32'h0);
    ctl.init_seq();
    wb(1'b0, OFF_STATUS, 32'h0);
    chk(q & 32'h7, 32'h2);
    wb(1'b0, OFF_EXT2, 32'h0);
    chk(q, 32'h80);
    wb(1'b0, OFF_MAIN, 32'h0);
    chk(q, 32'h3);
    lim = 0;
    while (rdy !== 1'b1 && lim < 300) begin
      @(posedge clk_in);
      lim++;
    end
    wb(1'b0, OFF_STATUS, 32'h0);
    chk(q, 32'h1);
    ctl.send(3'h0, 3'h4, 14'h0);
    wb(1'b0, OFF_STATUS, 32'h0);
    chk(q, 32'h5);
    wb(1'b1, OFF_CONTROL, 32'h1);
    wb(1'b0, OFF_STATUS, 32'h0);
    chk(q, 32'h1);
    for (m = 0; m < 4; m++) begin
      ctl.send(3'h0, BANK_MAIN, {10'h0, m[0], m[1] ? 3'h3 : 3'h2});
      wb(1'b0, OFF_MAIN, 32'h0);
      chk(q, {28'h0, m[0], m[1] ? 3'h3 : 3'h2});
      ctl.send({2'h2, m[0]}, 3'h0, 14'h02D5);
      #1;
      chk({31'h0, bwr}, {31'h0, ~m[0]});
      for (i = 0; i < (m[1] ? 8 : 4); i++) begin
        #1;
        e = m[1] ? {7'h5A, 3'(m[0] ? 5 ^ i : 5 + i)} : {8'hB5, 2'(m[0] ? 1 ^ i : 1 + i)};
        chk({22'h0, col}, {22'h0, e});
        @(posedge clk_in);
      end
      #1;
      chk({31'h0, act}, 32'h0);
    end
    conclude();
  end
endmodule
